// file: src/tcp_map.vh
// register offsets, field positions, reset values and divider counts
// for the 16-bit timer compare, single-pulse and pwm block.
// assumes a 32-bit ahb-lite bus, one aligned word per 8-bit register.
`ifndef TCP_MAP_VH
`define TCP_MAP_VH

////////////////////////////////////////////////////////////////////////
// byte offsets
`define TCP_OFS_CTRL1     6'h00
`define TCP_OFS_CTRL2     6'h04
`define TCP_OFS_STATUS    6'h08
`define TCP_OFS_CMP1_HI   6'h0c
`define TCP_OFS_CMP1_LO   6'h10
`define TCP_OFS_CMP2_HI   6'h14
`define TCP_OFS_CMP2_LO   6'h18
`define TCP_OFS_CAP1_HI   6'h1c
`define TCP_OFS_CAP1_LO   6'h20
`define TCP_OFS_CAP2_HI   6'h24
`define TCP_OFS_CAP2_LO   6'h28
`define TCP_OFS_CNT_HI    6'h2c
`define TCP_OFS_CNT_LO    6'h30

////////////////////////////////////////////////////////////////////////
// first control register fields
`define TCP_C1_CAP_IE     7
`define TCP_C1_CMP_IE     6
`define TCP_C1_FORCE2     4
`define TCP_C1_FORCE1     3
`define TCP_C1_LEVEL2     2
`define TCP_C1_EDGE1      1
`define TCP_C1_LEVEL1     0
// second control register fields
`define TCP_C2_PIN_EN1    7
`define TCP_C2_PIN_EN2    6
`define TCP_C2_PULSE      5
`define TCP_C2_PWM        4
`define TCP_C2_TICK_HI    3
`define TCP_C2_TICK_LO    2
`define TCP_C2_EDGE2      1
`define TCP_C2_EXT_EDGE   0
// status register fields
`define TCP_ST_CAP1       7
`define TCP_ST_CMP1       6
`define TCP_ST_CAP2       4
`define TCP_ST_CMP2       3

////////////////////////////////////////////////////////////////////////
// reset and reload values, tick selects
`define TCP_CTRL_RESET    8'h00
`define TCP_CMP_RESET     16'h8000
`define TCP_CNT_RELOAD    16'hfffc
`define TCP_CAP_PULSE     16'hfffd
`define TCP_TICK_DIV2     2'h0
`define TCP_TICK_DIV4     2'h1
`define TCP_TICK_DIV8     2'h2
`define TCP_TICK_EXT      2'h3
`define TCP_DIV2_LAST     3'h1
`define TCP_DIV4_LAST     3'h3
`define TCP_DIV8_LAST     3'h7

`endif

// file: src/tcp_timer.v
// compare, single-pulse and pwm logic of a 16-bit free-running timer,
// with its counter, tick divider and an ahb-lite register slave.
// assumes pins arrive asynchronous to hclk; irq mask comes from hclk logic.
`include "tcp_map.vh"

// Function
// R1 - counter equal to compare sets flag, drives enabled pin, requests irq
// R2 - compare pin latches held low during reset
// R3 - flag clears after status read with flag set, then low byte access
// R4 - high byte write suppresses compare until low byte written
// R5 - disabled pin ignores matches; match may still interrupt
// R6 - flag and pin change when counter enters the compare value
// R7 - force bit copies level to enabled pin, no flag, no irq
// R8 - force bits ignored in single-pulse or pwm mode
// R9 - single-pulse uses capture 1 trigger and compare 1 end on pin 1
// R10 - trigger loads counter fffc, pin 1 gets level 2, capture fffd
// R11 - single-pulse compare 1 match drives level 1 onto pin 1
// R12 - single-pulse never sets compare flag 1; channel 2 still flags
// R13 - single-pulse compare 2 does not drive pin 2
// R14 - single-pulse capture 1 does not capture; capture 2 still works
// R15 - pwm and single-pulse both set means pwm only
// R16 - pwm compare values double-buffered, loaded at channel 2 match
// R17 - pwm match 1 drives level 1, match 2 drives level 2 on pin 1
// R18 - pwm channel 2 match reloads counter with fffc
// R19 - pwm sets neither compare flag
// R20 - pwm sets capture flag 1 at compare 2 match
// R21 - pwm disconnects capture 1; capture 2 still captures
// R22 - tick is hclk over 2, 4, 8 or external clock
// R23 - reset loads compare values with 8000; only software changes them
// R24 - tick select 11 picks external clock, edge by edge select
module tcp_timer (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        cpu_irq_mask,
    input  wire        capture_input_pin1,
    input  wire        capture_input_pin2,
    input  wire        ext_clock_pin,
    output reg         compare_output_pin1,
    output wire        compare_output_oe1,
    output reg         compare_output_pin2,
    output wire        compare_output_oe2,
    output wire        timer_irq,
    output wire [15:0] free_count
);

    ////////////////////////////////////////////////////////////////////
    // state
    reg  [7:0]  ctrl1;
    reg  [7:0]  ctrl2;
    reg  [15:0] compare_value_reg1;
    reg  [15:0] compare_value_reg2;
    reg  [15:0] cmp_act1;
    reg  [15:0] cmp_act2;
    reg  [15:0] capture_value_reg1;
    reg  [15:0] capture_value_reg2;
    reg  [15:0] count;
    reg  [2:0]  div;
    reg         inhibit1;
    reg         inhibit2;
    reg         match_flag1;
    reg         match_flag2;
    reg         capture_flag1;
    reg         capture_flag2;
    reg         arm_m1;
    reg         arm_m2;
    reg         arm_c1;
    reg         arm_c2;
    reg  [2:0]  cap1_s;
    reg  [2:0]  cap2_s;
    reg  [2:0]  ext_s;
    reg         dp_wr;
    reg  [5:0]  dp_addr;

    ////////////////////////////////////////////////////////////////////
    // mode decode
    // R15 pwm wins
    wire pwm_mode   = ctrl2[`TCP_C2_PWM];
    wire pulse_mode = ctrl2[`TCP_C2_PULSE] & ~pwm_mode;
    wire plain_mode = ~pwm_mode & ~pulse_mode;
    wire pin_en1    = ctrl2[`TCP_C2_PIN_EN1];
    wire pin_en2    = ctrl2[`TCP_C2_PIN_EN2];
    wire level1     = ctrl1[`TCP_C1_LEVEL1];
    wire level2     = ctrl1[`TCP_C1_LEVEL2];
    wire [1:0] tick_select = {ctrl2[`TCP_C2_TICK_HI], ctrl2[`TCP_C2_TICK_LO]};

    assign compare_output_oe1 = pin_en1;
    assign compare_output_oe2 = pin_en2;
    assign free_count         = count;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage 0 is read only by stage 1
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap1_s <= 3'h0;
            cap2_s <= 3'h0;
            ext_s  <= 3'h0;
        end else begin
            cap1_s <= {cap1_s[1:0], capture_input_pin1};
            cap2_s <= {cap2_s[1:0], capture_input_pin2};
            ext_s  <= {ext_s[1:0], ext_clock_pin};
        end
    end

    // stage 2 is a plain delay of the synchronised level for edges
    wire cap1_rise = cap1_s[1] & ~cap1_s[2];
    wire cap1_fall = ~cap1_s[1] & cap1_s[2];
    wire cap2_rise = cap2_s[1] & ~cap2_s[2];
    wire cap2_fall = ~cap2_s[1] & cap2_s[2];
    wire ext_rise  = ext_s[1] & ~ext_s[2];
    wire ext_fall  = ~ext_s[1] & ext_s[2];
    wire cap1_edge = ctrl1[`TCP_C1_EDGE1] ? cap1_rise : cap1_fall;
    wire cap2_edge = ctrl2[`TCP_C2_EDGE2] ? cap2_rise : cap2_fall;

    ////////////////////////////////////////////////////////////////////
    // tick generation
    // R22 divider last count per select
    reg [2:0] div_last;
    always @* begin
        case (tick_select)
            `TCP_TICK_DIV2: div_last = `TCP_DIV2_LAST;
            `TCP_TICK_DIV4: div_last = `TCP_DIV4_LAST;
            default:        div_last = `TCP_DIV8_LAST;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            div <= 3'h0;
        else if (div >= div_last)
            div <= 3'h0;
        else
            div <= div + 3'h1;
    end

    // R24 external edge when both select bits set
    wire ext_tick = ctrl2[`TCP_C2_EXT_EDGE] ? ext_rise : ext_fall;
    wire tick = (tick_select == `TCP_TICK_EXT) ? ext_tick
                                               : (div >= div_last);

    ////////////////////////////////////////////////////////////////////
    // counter and match detection
    // R9 single-pulse trigger is capture input 1
    wire pulse_trig = pulse_mode & cap1_edge;
    wire end_period = pwm_mode & (count == cmp_act2);
    wire [15:0] next_count = end_period ? `TCP_CNT_RELOAD
                                        : count + 16'h0001;

    // R6 match fires as the counter enters the compare value
    // R4 suppressed between high and low byte writes
    // outside pwm compare the live value: the copy lags one cycle
    wire [15:0] cmp_use1 = pwm_mode ? cmp_act1 : compare_value_reg1;
    wire [15:0] cmp_use2 = pwm_mode ? cmp_act2 : compare_value_reg2;
    wire match1 = tick & ~pulse_trig & ~inhibit1 & (next_count == cmp_use1);
    wire match2 = tick & ~pulse_trig & ~inhibit2 & (next_count == cmp_use2);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            count <= `TCP_CNT_RELOAD;
        // R10 trigger restarts the counter
        else if (pulse_trig)
            count <= `TCP_CNT_RELOAD;
        // R18 pwm period restart
        else if (tick)
            count <= next_count;
    end

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave: reads answered from flops, zero wait
    wire        ap_valid = hsel & hready & htrans[1];
    wire [5:0]  ap_addr  = haddr[5:0];
    wire        ap_rd    = ap_valid & ~hwrite;
    wire        wr_now   = dp_wr;
    wire [7:0]  wbyte    = hwdata[7:0];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_addr <= 6'h00;
        end else if (hready) begin
            dp_wr   <= ap_valid & hwrite;
            dp_addr <= ap_addr;
        end
    end

    wire wr_c1h = wr_now & (dp_addr == `TCP_OFS_CMP1_HI);
    wire wr_c1l = wr_now & (dp_addr == `TCP_OFS_CMP1_LO);
    wire wr_c2h = wr_now & (dp_addr == `TCP_OFS_CMP2_HI);
    wire wr_c2l = wr_now & (dp_addr == `TCP_OFS_CMP2_LO);
    wire rd_st  = ap_rd & (ap_addr == `TCP_OFS_STATUS);

    // low byte accesses, read or write, finish a flag clear
    wire acc_c1l = wr_c1l | (ap_rd & (ap_addr == `TCP_OFS_CMP1_LO));
    wire acc_c2l = wr_c2l | (ap_rd & (ap_addr == `TCP_OFS_CMP2_LO));
    wire acc_p1l = (wr_now & (dp_addr == `TCP_OFS_CAP1_LO))
                 | (ap_rd & (ap_addr == `TCP_OFS_CAP1_LO));
    wire acc_p2l = (wr_now & (dp_addr == `TCP_OFS_CAP2_LO))
                 | (ap_rd & (ap_addr == `TCP_OFS_CAP2_LO));

    wire [7:0] status = {capture_flag1, match_flag1, 1'b0, capture_flag2,
                         match_flag2, 3'h0};

    reg [7:0] next_rd;
    always @* begin
        case (ap_addr)
            `TCP_OFS_CTRL1:   next_rd = ctrl1;
            `TCP_OFS_CTRL2:   next_rd = ctrl2;
            `TCP_OFS_STATUS:  next_rd = status;
            `TCP_OFS_CMP1_HI: next_rd = compare_value_reg1[15:8];
            `TCP_OFS_CMP1_LO: next_rd = compare_value_reg1[7:0];
            `TCP_OFS_CMP2_HI: next_rd = compare_value_reg2[15:8];
            `TCP_OFS_CMP2_LO: next_rd = compare_value_reg2[7:0];
            `TCP_OFS_CAP1_HI: next_rd = capture_value_reg1[15:8];
            `TCP_OFS_CAP1_LO: next_rd = capture_value_reg1[7:0];
            `TCP_OFS_CAP2_HI: next_rd = capture_value_reg2[15:8];
            `TCP_OFS_CAP2_LO: next_rd = capture_value_reg2[7:0];
            `TCP_OFS_CNT_HI:  next_rd = count[15:8];
            `TCP_OFS_CNT_LO:  next_rd = count[7:0];
            default:          next_rd = 8'h00;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (ap_rd)
            hrdata <= {24'h000000, next_rd};
    end

    ////////////////////////////////////////////////////////////////////
    // control and compare registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl1 <= `TCP_CTRL_RESET;
            ctrl2 <= `TCP_CTRL_RESET;
            // R23 compare reset value
            compare_value_reg1 <= `TCP_CMP_RESET;
            compare_value_reg2 <= `TCP_CMP_RESET;
            inhibit1 <= 1'b0;
            inhibit2 <= 1'b0;
        end else begin
            if (wr_now & (dp_addr == `TCP_OFS_CTRL1))
                ctrl1 <= wbyte;
            if (wr_now & (dp_addr == `TCP_OFS_CTRL2))
                ctrl2 <= wbyte;
            if (wr_c1h)
                compare_value_reg1[15:8] <= wbyte;
            if (wr_c1l)
                compare_value_reg1[7:0] <= wbyte;
            if (wr_c2h)
                compare_value_reg2[15:8] <= wbyte;
            if (wr_c2l)
                compare_value_reg2[7:0] <= wbyte;
            // R4 high write stops compare, low write restarts it
            if (wr_c1h)
                inhibit1 <= 1'b1;
            else if (wr_c1l)
                inhibit1 <= 1'b0;
            if (wr_c2h)
                inhibit2 <= 1'b1;
            else if (wr_c2l)
                inhibit2 <= 1'b0;
        end
    end

    // R16 active copies follow software outside pwm, load at period end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_act1 <= `TCP_CMP_RESET;
            cmp_act2 <= `TCP_CMP_RESET;
        end else if (~pwm_mode | (tick & end_period)) begin
            cmp_act1 <= compare_value_reg1;
            cmp_act2 <= compare_value_reg2;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status flags: a set in the clearing cycle wins
    // R12 R19 flag 1 only in plain mode, flag 2 outside pwm
    wire set_m1 = match1 & plain_mode;
    wire set_m2 = match2 & ~pwm_mode;
    // R14 R21 capture 1 only in plain mode; R20 pwm period sets it
    wire cap1_plain = plain_mode & cap1_edge;
    wire set_c1 = cap1_plain | pulse_trig | (pwm_mode & match2);
    wire set_c2 = cap2_edge;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_flag1   <= 1'b0;
            match_flag2   <= 1'b0;
            capture_flag1 <= 1'b0;
            capture_flag2 <= 1'b0;
            arm_m1 <= 1'b0;
            arm_m2 <= 1'b0;
            arm_c1 <= 1'b0;
            arm_c2 <= 1'b0;
        end else begin
            // R1 match flag set
            match_flag1   <= set_m1 | (match_flag1 & ~(arm_m1 & acc_c1l));
            match_flag2   <= set_m2 | (match_flag2 & ~(arm_m2 & acc_c2l));
            capture_flag1 <= set_c1 | (capture_flag1 & ~(arm_c1 & acc_p1l));
            capture_flag2 <= set_c2 | (capture_flag2 & ~(arm_c2 & acc_p2l));
            // R3 status read with flag set arms the clear
            arm_m1 <= (rd_st & match_flag1) | (arm_m1 & ~acc_c1l);
            arm_m2 <= (rd_st & match_flag2) | (arm_m2 & ~acc_c2l);
            arm_c1 <= (rd_st & capture_flag1) | (arm_c1 & ~acc_p1l);
            arm_c2 <= (rd_st & capture_flag2) | (arm_c2 & ~acc_p2l);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // capture registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_value_reg1 <= 16'h0000;
            capture_value_reg2 <= 16'h0000;
        end else begin
            // R10 trigger writes the fixed capture value
            if (pulse_trig)
                capture_value_reg1 <= `TCP_CAP_PULSE;
            else if (cap1_plain)
                capture_value_reg1 <= count;
            // R14 R21 channel 2 captures in every mode
            if (cap2_edge)
                capture_value_reg2 <= count;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt request, one shared line
    // R1 gated by enables and the cpu mask
    assign timer_irq = ~cpu_irq_mask &
        ((ctrl1[`TCP_C1_CAP_IE] & (capture_flag1 | capture_flag2)) |
         (ctrl1[`TCP_C1_CMP_IE] & (match_flag1 | match_flag2)));

    ////////////////////////////////////////////////////////////////////
    // output pin latches
    // R8 force only in plain mode
    wire force1 = plain_mode & ctrl1[`TCP_C1_FORCE1];
    wire force2 = plain_mode & ctrl1[`TCP_C1_FORCE2];

    always @(posedge hclk or negedge hresetn) begin
        // R2 latches low in reset
        if (!hresetn) begin
            compare_output_pin1 <= 1'b0;
            compare_output_pin2 <= 1'b0;
        end else begin
            // R5 disabled pin keeps its latch
            if (pin_en1) begin
                // R10 pulse start level
                if (pulse_trig)
                    compare_output_pin1 <= level2;
                // R17 pwm period end level
                else if (pwm_mode & match2)
                    compare_output_pin1 <= level2;
                // R11 R17 compare 1 drives level 1 in every mode
                else if (match1)
                    compare_output_pin1 <= level1;
                // R7 force copies level
                else if (force1)
                    compare_output_pin1 <= level1;
            end
            // R13 pin 2 only driven in plain mode
            if (pin_en2 & plain_mode & (match2 | force2))
                compare_output_pin2 <= level2;
        end
    end

endmodule

// file: testbench/tcp_timer_properties.sv
// port-level assertions for the timer compare, pulse and pwm block
// assumes the control registers change only by the ahb writes seen here
`include "tcp_map.vh"
module tcp_timer_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        compare_output_pin1,
    input wire        compare_output_oe1,
    input wire        compare_output_pin2,
    input wire        compare_output_oe2,
    input wire [15:0] free_count
);
timeunit 1ns;
timeprecision 1ps;
////////////////////////////////////////////////////////////////////////
// shadow of both control registers, taken in the write data phase
reg       pend;
reg [5:0] adr;
reg [7:0] c1;
reg [7:0] c2;
wire      spm   = c2[5] & ~c2[4];
wire      plain = ~c2[5] & ~c2[4];
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pend <= 1'b0;
        adr  <= 6'h00;
        c1   <= 8'h00;
        c2   <= 8'h00;
    end else begin
        pend <= hsel & hready & htrans[1] & hwrite;
        adr  <= haddr[5:0];
        if (pend && adr == `TCP_OFS_CTRL1)
            c1 <= hwdata[7:0];
        if (pend && adr == `TCP_OFS_CTRL2)
            c2 <= hwdata[7:0];
    end
end
////////////////////////////////////////////////////////////////////////
default clocking dcb @(posedge hclk);
endclocking
default disable iff (!hresetn);

property p_reset_low;
    disable iff (1'b0)
    !hresetn |-> !compare_output_pin1 && !compare_output_pin2;
endproperty
a_reset_low: assert property (p_reset_low)
    else $error("pin high in reset");

property p_oe_bits;
    compare_output_oe1 == c2[7] && compare_output_oe2 == c2[6];
endproperty
a_oe_bits: assert property (p_oe_bits)
    else $error("pin enable differs from control bit");

// needs two quiet samples: the pin lags the control write by one edge
property p_force;
    plain && c1[3] ##1 $stable(c1) && $stable(c2) && compare_output_oe1
    |-> compare_output_pin1 == c1[0];
endproperty
a_force: assert property (p_force)
    else $error("forced pin not at level");

property p_count_step;
    $changed(free_count) |-> free_count == $past(free_count) + 16'h1
        || free_count == `TCP_CNT_RELOAD;
endproperty
a_count_step: assert property (p_count_step)
    else $error("count jumped");

property p_div2;
    plain && c2[3:2] == 2'h0 && $stable(c2) && $changed(free_count)
    |=> $stable(free_count);
endproperty
a_div2: assert property (p_div2)
    else $error("count too fast");

property p_pin2_quiet;
    spm && $past(spm) |-> $stable(compare_output_pin2);
endproperty
a_pin2_quiet: assert property (p_pin2_quiet)
    else $error("pin 2 moved in pulse mode");

property p_trigger;
    spm && $stable(c2) && compare_output_oe1 && $changed(free_count)
    && free_count == 16'hfffc && $past(free_count) != 16'hfffb
    |-> compare_output_pin1 == c1[2];
endproperty
a_trigger: assert property (p_trigger)
    else $error("pulse start level wrong");

property p_pwm_reload;
    c2[4] && $stable(c2) && compare_output_oe1 && $changed(free_count)
    && free_count == 16'hfffc && $past(free_count) != 16'hfffb
    |-> compare_output_pin1 == c1[2];
endproperty
a_pwm_reload: assert property (p_pwm_reload)
    else $error("period end level wrong");
endmodule

bind tcp_timer tcp_timer_checker u_chk (.*);

// file: testbench/tcp_pin_model.sv
// pin side of the timer: trigger pulses on capture pin 1, external tick
// assumes trig1 is a one-cycle request from the bench
module tcp_pin_model (
    input  wire  hclk,
    input  wire  hresetn,
    input  wire  trig1,
    output logic ext_pin,
    output wire  cap_pin1,
    output wire  cap_pin2
);
timeunit 1ns;
timeprecision 1ps;
logic [1:0] div;
logic [2:0] hold;
// capture 2 is left quiet, so its capture path goes untested
assign cap_pin2 = 1'b0;
// trigger edge held past the synchroniser
assign cap_pin1 = (hold != 3'h0);
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        div     <= 2'h0;
        hold    <= 3'h0;
        ext_pin <= 1'b0;
    end else begin
        div <= div + 2'h1;
        // tick of period 8 hclk, below a quarter rate
        if (div == 2'h3)
            ext_pin <= ~ext_pin;
        if (trig1)
            hold <= 3'h6;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end
end
endmodule

// file: testbench/tb_tcp_timer.sv
// self-checking bench for the timer compare, pulse and pwm block
// assumes a single zero-wait ahb-lite slave and the pin model beside it
`include "tcp_map.vh"
module tb_tcp_timer;
timeunit 1ns;
timeprecision 1ps;
logic        hclk;
logic        hresetn;
logic        hsel;
logic [31:0] haddr;
logic [1:0]  htrans;
logic        hwrite;
logic [31:0] hwdata;
logic        irq_mask;
logic        trig1;
wire  [31:0] hrdata;
wire         hrdy;
wire         hresp;
wire         p1;
wire         p2;
wire         oe1;
wire         oe2;
wire         irq;
wire  [15:0] fc;
wire         cap1;
wire         cap2;
wire         ext;
int          num_errors;
int          checks;

tcp_timer dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
    .cpu_irq_mask(irq_mask), .capture_input_pin1(cap1),
    .capture_input_pin2(cap2), .ext_clock_pin(ext),
    .compare_output_pin1(p1), .compare_output_oe1(oe1),
    .compare_output_pin2(p2), .compare_output_oe2(oe2),
    .timer_irq(irq), .free_count(fc)
);
tcp_pin_model pins_u (
    .hclk(hclk), .hresetn(hresetn), .trig1(trig1),
    .ext_pin(ext), .cap_pin1(cap1), .cap_pin2(cap2)
);
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
        num_errors++;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
endtask
task automatic wait_rdy;
    do
        @(posedge hclk);
    while (hrdy !== 1'b1);
endtask
task automatic bus(input logic w, input logic [5:0] a,
                   input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {26'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata[7:0];
endtask
task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
endtask
task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({8'h0, q}, {8'h0, e});
endtask
// waits for a count value; a late arrival counts as a mismatch
task automatic wait_fc(input logic [15:0] v, input int lim);
    int n;
    n = 0;
    checks++;
    do begin
        @(posedge hclk);
        #1;
        n++;
    end while (fc !== v && n < lim);
    if (fc !== v) begin
        num_errors++;
        $display("unexpected at %0t: count %h late", $time, v);
    end
endtask
task automatic trigger;
    @(posedge hclk);
    trig1 <= 1'b1;
    @(posedge hclk);
    trig1 <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    check(16'({p1, p2, hresp}), 16'h0);
    rdchk(`TCP_OFS_CMP1_HI, 8'h80);
    rdchk(`TCP_OFS_CMP1_LO, 8'h00);
    rdchk(`TCP_OFS_CMP2_HI, 8'h80);
    rdchk(`TCP_OFS_CTRL2, 8'h00);
    rdchk(6'h34, 8'h00);
endtask
task automatic t_compare;
    wr(`TCP_OFS_CMP1_HI, 8'h01);
    wr(`TCP_OFS_CMP1_LO, 8'h00);
    wr(`TCP_OFS_CMP2_HI, 8'h01);
    wr(`TCP_OFS_CMP2_LO, 8'h80);
    rdchk(`TCP_OFS_CMP2_LO, 8'h80);
    wr(`TCP_OFS_CTRL1, 8'h45);
    wr(`TCP_OFS_CTRL2, 8'h80);
    wait_fc(16'h0100, 600);
    check(16'({p1, irq}), 16'h3);
    rdchk(`TCP_OFS_CMP1_LO, 8'h00);
    #1;
    check(16'(irq), 16'h1);
    rdchk(`TCP_OFS_STATUS, 8'h40);
    rdchk(`TCP_OFS_CMP1_LO, 8'h00);
    #1;
    check(16'(irq), 16'h0);
    wait_fc(16'h0180, 300);
    check(16'({oe2, p2, irq}), 16'h1);
    rdchk(`TCP_OFS_STATUS, 8'h08);
    rdchk(`TCP_OFS_CMP2_LO, 8'h80);
    wr(`TCP_OFS_CMP1_HI, 8'h02);
    wait_fc(16'h0201, 400);
    rdchk(`TCP_OFS_STATUS, 8'h00);
    wr(`TCP_OFS_CMP1_LO, 8'h00);
endtask
task automatic t_force;
    wr(`TCP_OFS_CTRL2, 8'hc0);
    for (int i = 0; i < 2; i++) begin
        wr(`TCP_OFS_CTRL1, {5'h03, i[0], 1'b0, i[0]});
        @(posedge hclk);
        #1;
        check(16'({p1, p2}), 16'({i[0], i[0]}));
    end
    rdchk(`TCP_OFS_STATUS, 8'h00);
endtask
task automatic t_pulse;
    wr(`TCP_OFS_CMP1_HI, 8'h00);
    wr(`TCP_OFS_CMP1_LO, 8'h10);
    wr(`TCP_OFS_CTRL1, 8'h18);
    wr(`TCP_OFS_CTRL2, 8'he0);
    wr(`TCP_OFS_CTRL1, 8'h16);
    trigger();
    wait_fc(16'hfffc, 12);
    check(16'({p1, p2}), 16'h2);
    rdchk(`TCP_OFS_CAP1_HI, 8'hff);
    rdchk(`TCP_OFS_CAP1_LO, 8'hfd);
    wait_fc(16'h0010, 60);
    check(16'(p1), 16'h0);
    rdchk(`TCP_OFS_STATUS, 8'h80);
endtask
task automatic t_pwm;
    wr(`TCP_OFS_CMP1_LO, 8'h08);
    wr(`TCP_OFS_CMP2_HI, 8'h00);
    wr(`TCP_OFS_CMP2_LO, 8'h20);
    wr(`TCP_OFS_CTRL1, 8'h81);
    trigger();
    wait_fc(16'hfffc, 12);
    wr(`TCP_OFS_CTRL2, 8'hb0);
    wait_fc(16'h0009, 40);
    check(16'(p1), 16'h1);
    wait_fc(16'h0020, 60);
    check(16'(p1), 16'h0);
    wait_fc(16'hfffc, 4);
    rdchk(`TCP_OFS_STATUS, 8'h80);
    rdchk(`TCP_OFS_CAP1_LO, 8'hfd);
    wr(`TCP_OFS_CMP1_HI, 8'h00);
    wr(`TCP_OFS_CMP1_LO, 8'h18);
    wr(`TCP_OFS_CMP2_HI, 8'h00);
    wr(`TCP_OFS_CMP2_LO, 8'h30);
    trigger();
    wait_fc(16'h0020, 64);
    wait_fc(16'hfffc, 4);
    check(16'(irq), 16'h1);
    rdchk(`TCP_OFS_STATUS, 8'h80);
    @(posedge hclk);
    irq_mask <= 1'b1;
    @(posedge hclk);
    #1;
    check(16'(irq), 16'h0);
    @(posedge hclk);
    irq_mask <= 1'b0;
    wait_fc(16'h0019, 60);
    check(16'(p1), 16'h1);
    wait_fc(16'h0030, 60);
    check(16'(p1), 16'h0);
endtask
task automatic t_tick;
    logic [15:0] c0;
    int          n;
    for (int i = 0; i < 4; i++) begin
        wr(`TCP_OFS_CTRL2, {4'h0, i[1:0], 1'b0, i == 3});
        n = 0;
        c0 = fc;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (fc === c0 && n < 40);
        c0 = fc;
        repeat ((i == 3 ? 8 : 2 << i) * 8) @(posedge hclk);
        #1;
        check(fc - c0, 16'h8);
    end
endtask
////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
end
// run is near 1600 cycles; the limit leaves ample slack
initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
end
initial begin
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hwdata   = 32'h0;
    irq_mask = 1'b0;
    trig1    = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_compare();
    t_force();
    t_pulse();
    t_pwm();
    t_tick();
    wrap_up();
end
endmodule
